// File: dv/test_sicr.sv
`timescale 1ns/10ps
`default_nettype none
module test_sicr;
	import sicr_pkg::*;
	logic clk = 0, rstn = 0, rd_s = 0, wr_s = 0, below = 0, stop = 0, lock = 0, sess = 0, halt = 0;
	logic wack = 0, gack = 0, srco = 0, wmode = 0, uvo = 1;
	logic [1:0] addr = 0;
	logic [3:0] be = 0;
	logic [31:0] wdata = 0, rdata;
	logic wreq, wirq, girq, wake, lon, vgnd, lcu, det;
	sicr_rst_type cause = SICR_RST_PIN;
	int n_errors = 0, samples_checked = 0, i;
	logic [7:0] q, d;
	sicr_rst_type cs [5] = '{SICR_RST_UV, SICR_RST_WDOG, SICR_RST_PIN, SICR_RST_WDOG, SICR_RST_UV};
	logic [7:0] cx [5] = '{8'h10, 8'h11, 8'h10, 8'h01, 8'h10};
	logic [7:0] wd [7] = '{8'h88, 8'h8a, 8'h82, 8'h88, 8'h80, 8'h82, 8'ha0};
	logic [7:0] ex [7] = '{8'h88, 8'h8a, 8'h8a, 8'h88, 8'h80, 8'h80, 8'ha0};
	sicr_top uut (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
		.RESET_CAUSE(cause), .UV_DETECT_OPTION(uvo), .SOURCE_OPTION(srco), .SUPPLY_BELOW(below),
		.OSC_STOPPED(stop), .LOOP_LOCKED(lock), .SESSION_ENTRY(sess), .HALT_MODE(halt), .WAIT_MODE(wmode),
		.WARN_IRQ_ACK(wack), .GUARD_IRQ_ACK(gack), .WARN_IRQ(wirq), .GUARD_IRQ(girq), .WAKE_REQ(wake),
		.LOOP_ON(lon), .DETECTOR_ON(det), .VCO_GROUNDED(vgnd), .LOOP_CLOCK_USED(lcu));
	initial begin
		forever #50 clk = ~clk;
	end
	function automatic logic [7:0] p0w(input logic [7:0] v);
		return v & 8'h44;
	endfunction
	task conclude;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] s, input string nm);
		samples_checked++;
		if (s !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask
	// Waitrequest and read data are both taken at the rising edge that completes the transfer
	task xfer(input logic r, input logic [1:0] a, input logic [7:0] dt, input logic [3:0] b);
		int k;
		@(posedge clk);
		rd_s <= r;
		wr_s <= ~r;
		addr <= a;
		wdata <= {24'h0, dt};
		be <= b;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (wreq === 1'b0) break;
		end
		if (k == 20) begin
			n_errors++;
			conclude;
		end
		q = rdata[7:0];
		rd_s <= 0;
		wr_s <= 0;
	endtask
	task rdx(input logic [7:0] e);
		xfer(1, 2'h0, 8'h00, 4'hf);
		chk({24'h0, e}, {rdata[31:8], q}, "readback");
	endtask
	task wr(input logic [7:0] dt);
		xfer(0, 2'h0, dt, 4'h1);
	endtask
	task rst(input sicr_rst_type c);
		cause <= c;
		rstn <= 0;
		repeat (4) @(posedge clk);
		rstn <= 1;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude;
	end
	initial begin
		void'($urandom(32'h0aad4af9));
		for (i = 0; i < 5; i++) begin
			if (i == 3) wr(8'h00);
			rst(cs[i]);
			rdx(cx[i]);
		end
		$display("test reset_flags done");
		wr(8'h80);
		rdx(8'h80);
		for (i = 0; i < 7; i++) begin
			wr(wd[i]);
			rdx(ex[i]);
			chk(ex[i][3], lon, "loop_on");
			chk(ex[i][1], lcu, "clock_used");
		end
		chk(1, vgnd, "vco_grounded");
		wr(8'h88);
		srco <= 1;
		@(posedge clk);
		chk(1, lcu, "forced_source");
		wr(8'h80);
		chk(1, lcu, "forced_keep_loop");
		wr(8'h8a);
		wr(8'h88);
		chk(1, lcu, "forced_source_sel");
		srco <= 0;
		lock <= 1;
		wr(8'h88);
		repeat (8) @(posedge clk);
		rdx(8'h98);
		lock <= 0;
		$display("test paging done");
		wr(8'h00);
		wr(8'h40);
		below <= 1;
		for (i = 0; i < 20 && wirq !== 1'b1; i++) @(negedge clk);
		chk(1, wirq, "warn_irq");
		@(posedge clk);
		halt <= 1;
		@(negedge clk);
		chk(1, wake, "wake_req");
		rdx(8'h60);
		halt <= 0;
		wack <= 1;
		@(posedge clk);
		wack <= 0;
		repeat (2) @(negedge clk);
		chk(0, wirq, "warn_ack");
		@(posedge clk);
		below <= 0;
		for (i = 0; i < 20 && wirq !== 1'b1; i++) @(negedge clk);
		chk(1, wirq, "warn_irq_fall");
		$display("test warning done");
		wr(8'h80);
		wr(8'h08);
		wr(8'h04);
		stop <= 1;
		for (i = 0; i < 20 && girq !== 1'b1; i++) @(negedge clk);
		chk(1, girq, "guard_irq");
		chk(0, wake, "wake_idle");
		@(posedge clk);
		stop <= 0;
		wmode <= 1;
		@(negedge clk);
		chk(1, wake, "wake_wait");
		@(posedge clk);
		wmode <= 0;
		gack <= 1;
		halt <= 1;
		@(posedge clk);
		gack <= 0;
		@(negedge clk);
		chk(0, det, "detector_halt");
		@(posedge clk);
		halt <= 0;
		repeat (8) @(posedge clk);
		chk(0, girq, "guard_ack");
		chk(1, det, "detector_on");
		rdx(8'h06);
		rdx(8'h04);
		stop <= 1;
		wr(8'h80);
		wr(8'h00);
		wr(8'h04);
		rdx(8'h04);
		stop <= 0;
		repeat (8) @(posedge clk);
		$display("test guard done");
		wr(8'h80);
		sess <= 1;
		@(posedge clk);
		sess <= 0;
		rdx(8'haa);
		xfer(0, 2'h1, 8'h80, 4'h1);
		xfer(0, 2'h0, 8'h80, 4'he);
		rdx(8'haa);
		wr(8'h00);
		below <= 1;
		uvo <= 0;
		repeat (8) @(posedge clk);
		rdx(8'h00);
		uvo <= 1;
		repeat (8) @(posedge clk);
		rdx(8'h20);
		below <= 0;
		repeat (8) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			d = $urandom;
			wr(p0w(d));
			rdx(p0w(d));
		end
		$display("test session_random done");
		conclude;
	end
endmodule
`default_nettype wire

// File: logic/sicr_edge.sv
`timescale 1ns/10ps
`default_nettype none
// Sticky request on a chosen edge kind; set wins over clear
module sicr_edge (
	input wire logic clk,
	input wire logic rstn,
	input wire logic level,
	input wire logic any_edge,
	input wire logic enable,
	input wire logic clear,
	output logic pend
);
	logic last_q, pend_q;
	logic hit;
	assign hit = enable && (any_edge ? (level != last_q) : (level && !last_q));
	always_ff @(posedge clk) begin
		if (!rstn) begin
			last_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			last_q <= level;
			pend_q <= hit || (pend_q && !clear && enable);
		end
	end
	assign pend = pend_q;
endmodule
`default_nettype wire

// File: logic/sicr_pkg.sv
// Operation
// R1 - Bit 7 selects page: 0 reaches page 0 fields, 1 reaches page 1 fields.
// R2 - With warning interrupt enabled, each warning flag change raises request; cleared on service entry.
// R3 - Warning flag is read-only, follows comparator: 1 below threshold, 0 above.
// R4 - Undervoltage reset flag set by that reset, cleared by software writing zero.
// R5 - Undervoltage reset flag survives external and watchdog resets.
// R6 - Software writes zero to reserved bits: page 0 bit 3, page 1 bits 6,2,0.
// R7 - Clock guard interrupt requested when disturbance flag sets; ineffective while loop disabled.
// R8 - Disturbance flag set on oscillator loss; cleared by register read after recovery.
// R9 - Disturbance flag forced to zero while loop enable is zero.
// R10 - Watchdog reset flag set by watchdog reset; cleared by zero write or undervoltage reset.
// R11 - Reset flag pair encodes last reset source: pin, watchdog or undervoltage.
// R12 - Loop mode 0 follows charge pump (16 MHz); 1 grounds VCO (10 MHz).
// R13 - Session entry sets loop mode, loop enable and clock source select to one.
// R14 - Lock bit read-only, set by hardware when loop reaches frequency.
// R15 - Loop enable powers loop and detector; clearing refused while loop clock selected.
// R16 - Source select picks oscillator or loop; selecting loop refused while loop disabled.
// R17 - When option forces the source, software select writes do not affect the clock.
// R18 - After reset page 0 reads zero except reset flags; page 1 reads zero.
// R19 - Supply warning flag and interrupt operate only when undervoltage detection is optioned on.
// R20 - Both interrupts wake from Wait; only supply warning wakes from Halt.
// R21 - In Halt the clock guard is off; resumes on interrupt wake, reset wake restarts it.
// R22 - Page selector shared by both pages; writes touch only the selected page fields.
package sicr_pkg;
	localparam logic [1:0] SICR_ADDR_CTRL = 2'h0;
	localparam int SICR_DW = 32;
	localparam int B_PAGE = 7;
	localparam int B_P0_WIE = 6;
	localparam int B_P0_WFLAG = 5;
	localparam int B_P0_UVRF = 4;
	localparam int B_P0_GIE = 2;
	localparam int B_P0_DIST = 1;
	localparam int B_P0_WDRF = 0;
	localparam int B_P1_MODE = 5;
	localparam int B_P1_LOCK = 4;
	localparam int B_P1_LEN = 3;
	localparam int B_P1_SEL = 1;
	localparam logic [7:0] SICR_RESET_P1 = 8'h00;
	typedef enum logic [1:0] {
		SICR_RST_PIN = 2'b00,
		SICR_RST_WDOG = 2'b01,
		SICR_RST_UV = 2'b10
	} sicr_rst_type;
endpackage

// File: logic/sicr_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; output changes only once stages two and three agree
module sicr_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic din,
	output logic dout
);
	logic s1_q, s2_q, s3_q, out_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end
	assign dout = out_q;
endmodule
`default_nettype wire

// File: logic/sicr_top.sv
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module sicr_top
	import sicr_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic [1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [sicr_pkg::SICR_DW-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [sicr_pkg::SICR_DW-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire sicr_pkg::sicr_rst_type RESET_CAUSE,
	input wire logic UV_DETECT_OPTION,
	input wire logic SOURCE_OPTION,
	input wire logic SUPPLY_BELOW,
	input wire logic OSC_STOPPED,
	input wire logic LOOP_LOCKED,
	input wire logic SESSION_ENTRY,
	input wire logic HALT_MODE,
	input wire logic WAIT_MODE,
	input wire logic WARN_IRQ_ACK,
	input wire logic GUARD_IRQ_ACK,
	output logic WARN_IRQ,
	output logic GUARD_IRQ,
	output logic WAKE_REQ,
	output logic LOOP_ON,
	output logic DETECTOR_ON,
	output logic VCO_GROUNDED,
	output logic LOOP_CLOCK_USED
);
	import sicr_pkg::*;

	logic page_q, wie_q, gie_q, dist_q, uvrf_q, wdrf_q, mode_q, len_q, sel_q;
	logic ack_q, first_q;
	logic [7:0] rdata_q;
	logic supply_s, osc_s, lock_s;
	logic warn_pend, guard_pend;

	// Slow external levels pass the three-stage filter before use
	sicr_sync u_sync_supply (.clk(CLK_SYS), .rstn(RSTN), .din(SUPPLY_BELOW), .dout(supply_s));
	sicr_sync u_sync_osc (.clk(CLK_SYS), .rstn(RSTN), .din(OSC_STOPPED), .dout(osc_s));
	sicr_sync u_sync_lock (.clk(CLK_SYS), .rstn(RSTN), .din(LOOP_LOCKED), .dout(lock_s));

	// Bus decode; one wait cycle then answer
	wire hit = (AVS_ADDRESS == SICR_ADDR_CTRL);
	wire req = (AVS_READ || AVS_WRITE) && !ack_q;
	wire wr_go = AVS_WRITE && ack_q && hit && AVS_BYTEENABLE[0];
	wire rd_go = AVS_READ && ack_q && hit;
	wire [7:0] wd = AVS_WRITEDATA[7:0];
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;

	// Guard runs only with loop on and outside Halt; config kept through Halt
	wire guard_live = len_q && !HALT_MODE; // [R21]
	wire warn_live = UV_DETECT_OPTION; // [R19]
	wire flag_w = warn_live && supply_s; // [R3]
	wire dist_rd = len_q ? dist_q : 1'b0; // [R9]
	wire sel_eff = SOURCE_OPTION | sel_q; // [R17]

	// Write gating per page
	wire wr_p0 = wr_go && !page_q; // [R22]
	wire wr_p1 = wr_go && page_q; // [R22]
	wire want_sel = wd[B_P1_SEL];
	wire want_len = wd[B_P1_LEN];
	wire sel_ok = !want_sel || want_len || len_q; // [R16]
	// A source forced by option counts as selected, so the loop may not be switched off under it
	wire len_ok = want_len || !(sel_eff || (want_sel && sel_ok)); // [R15] [R17]

	wire [7:0] page0_v = {page_q, wie_q, flag_w, uvrf_q, 1'b0, gie_q, dist_rd, wdrf_q};
	wire [7:0] page1_v = {page_q, 1'b0, mode_q, lock_s && len_q, len_q, 1'b0, sel_q, 1'b0}; // [R14]
	wire [7:0] rd_v = page_q ? page1_v : page0_v; // [R1]

	// Disturbance set while guard live, clear on read only after recovery
	wire dist_set = guard_live && osc_s; // [R8]
	wire dist_clr = rd_go && !page_q && !osc_s; // [R8]

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= req;
			rdata_q <= (AVS_READ && !ack_q && hit) ? rd_v : rdata_q;
		end
	end
	assign AVS_READDATA = {24'h000000, rdata_q};

	// Control bits; reset returns them to zero, session entry forces loop clock
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			page_q <= 1'b0; // [R18]
			wie_q <= 1'b0;
			gie_q <= 1'b0;
			mode_q <= 1'b0;
			len_q <= 1'b0;
			sel_q <= 1'b0;
		end else if (SESSION_ENTRY) begin
			mode_q <= 1'b1; // [R13]
			len_q <= 1'b1; // [R13]
			sel_q <= 1'b1; // [R13]
		end else if (wr_go) begin
			page_q <= wd[B_PAGE]; // [R1]
			if (wr_p0) begin
				wie_q <= wd[B_P0_WIE];
				gie_q <= wd[B_P0_GIE];
			end
			if (wr_p1) begin
				mode_q <= wd[B_P1_MODE]; // [R12]
				if (len_ok) begin
					len_q <= want_len; // [R15]
				end
				if (sel_ok) begin
					sel_q <= want_sel; // [R16]
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			dist_q <= 1'b0;
		end else begin
			dist_q <= len_q && (dist_set || (dist_q && !dist_clr)); // [R9]
		end
	end

	// Reset-source flags: captured at first clock after release; undervoltage flag kept across pin/watchdog resets, watchdog flag cleared by pin reset
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RSTN && first_q) begin
			if (RESET_CAUSE == SICR_RST_UV) begin
				uvrf_q <= 1'b1; // [R4] [R11]
				wdrf_q <= 1'b0; // [R10]
			end else if (RESET_CAUSE == SICR_RST_WDOG) begin
				wdrf_q <= 1'b1; // [R10] [R11]
			end else begin
				wdrf_q <= 1'b0; // [R11]
			end
		end else if (wr_p0) begin
			if (!wd[B_P0_UVRF]) begin
				uvrf_q <= 1'b0; // [R4] [R5]
			end
			if (!wd[B_P0_WDRF]) begin
				wdrf_q <= 1'b0; // [R10]
			end
		end
	end

	// Requests: warning on any flag change, guard on disturbance set
	sicr_edge u_warn (.clk(CLK_SYS), .rstn(RSTN), .level(flag_w), .any_edge(1'b1),
		.enable(wie_q && warn_live), .clear(WARN_IRQ_ACK), .pend(warn_pend)); // [R2]
	sicr_edge u_guard (.clk(CLK_SYS), .rstn(RSTN), .level(dist_rd), .any_edge(1'b0),
		.enable(gie_q && len_q), .clear(GUARD_IRQ_ACK), .pend(guard_pend)); // [R7]

	assign WARN_IRQ = warn_pend;
	assign GUARD_IRQ = guard_pend;
	assign WAKE_REQ = warn_pend || (guard_pend && WAIT_MODE); // [R20]
	assign LOOP_ON = len_q;
	assign DETECTOR_ON = guard_live; // [R21]
	assign VCO_GROUNDED = mode_q; // [R12]
	assign LOOP_CLOCK_USED = sel_eff && len_q;

	warn_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!UV_DETECT_OPTION |-> !page0_v[B_P0_WFLAG]) else $error("warning flag with detection off"); // [R19]
	dist_forced_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!len_q |-> !page0_v[B_P0_DIST]) else $error("disturbance flag set while loop off"); // [R9]
	len_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		(sel_q && !SESSION_ENTRY) |=> len_q) else $error("loop disabled while selected"); // [R15]
	sel_need_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		$rose(sel_q) |-> len_q || $past(SESSION_ENTRY)) else $error("loop clock chosen while off"); // [R16]
	session_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		SESSION_ENTRY |=> mode_q && len_q && sel_q) else $error("session entry did not set bits"); // [R13]
	guard_irq_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		($rose(dist_rd) && gie_q && len_q) |=> GUARD_IRQ) else $error("guard request missing"); // [R7]
	warn_irq_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		($changed(flag_w) && wie_q && warn_live) |=> WARN_IRQ) else $error("warning request missing"); // [R2]
	wdrf_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		(wr_p0 && !wd[B_P0_WDRF] && !first_q) |=> !wdrf_q) else $error("watchdog flag not cleared"); // [R10]
	page_rd_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		page_q |-> rd_v[B_P1_LEN] == len_q) else $error("page one not shown"); // [R1]
endmodule
`default_nettype wire
